// >>> rtl/mpic_consts.svh
`ifndef MPIC_CONSTS_SVH
`define MPIC_CONSTS_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define MPIC_OFS_CTRL 8'h00
`define MPIC_OFS_FILL 8'h04
`define MPIC_OFS_MASK 8'h08
`define MPIC_OFS_LUT_ADDR 8'h0C
`define MPIC_OFS_LUT_DATA 8'h10
`define MPIC_OFS_STATUS 8'h14

// ****************************************************************
// Control fields
// ****************************************************************
`define MPIC_CTRL_BYPASS 0
`define MPIC_CTRL_INDEX 1
`define MPIC_CTRL_XPT_LSB 2
`define MPIC_CTRL_XPT_MSB 4
`define MPIC_CTRL_INTERP 5
`define MPIC_CTRL_KEY 6
`define MPIC_CTRL_WIDTH 7
`define MPIC_XPT_PINS 3'h7

// ****************************************************************
// Reset values
// ****************************************************************
`define MPIC_CTRL_RESET 7'h01
`define MPIC_FILL_RESET 24'h000000
`define MPIC_MASK_RESET 24'hFFFFFF

// ****************************************************************
// Sizes
// ****************************************************************
`define MPIC_PIX_W 24
`define MPIC_COEF_W 9
`define MPIC_LUT_DEPTH 256
`define MPIC_FIFO_DEPTH 16

`endif

// >>> rtl/mpic_pkg.sv
package mpic_pkg;

	// Sources that the crosspoint can place on an operand
	typedef enum logic [1:0] {
		MPIC_SRC_A = 2'h0,
		MPIC_SRC_B = 2'h1,
		MPIC_SRC_F = 2'h2
	} mpic_src_e;

	typedef logic [23:0] mpic_pix_t;

	typedef struct packed {
		mpic_pix_t one;
		mpic_pix_t two;
		logic [8:0] coef;
	} mpic_word_s;

endpackage : mpic_pkg

// >>> rtl/mpic_fifo_if.sv
`timescale 1ns/1ps
`default_nettype none

interface mpic_fifo_if #(parameter int WIDTH = 57);
	logic in_valid;
	logic in_ready;
	logic [WIDTH-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [WIDTH-1:0] out_data;

	modport buffer (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
	modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : mpic_fifo_if

`default_nettype wire

// >>> rtl/mpic_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module mpic_fifo #(
	parameter int WIDTH = 57,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Both sides
	mpic_fifo_if.buffer port
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic [AW:0] count_next;
	logic ready_reg;
	logic valid_reg;
	logic push;
	logic pop;

	assign push = port.in_valid && ready_reg;
	assign pop = valid_reg && port.out_ready;
	assign port.in_ready = ready_reg;
	assign port.out_valid = valid_reg;
	assign port.out_data = mem[rd_ptr_reg];

	always_comb begin
		count_next = count_reg;
		if (push && !pop) begin
			count_next = count_reg + (AW+1)'(1);
		end else if (pop && !push) begin
			count_next = count_reg - (AW+1)'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= port.in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + AW'(1);
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + AW'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_reg <= '0;
			ready_reg <= 1'b0;
			valid_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			ready_reg <= (count_next < (AW+1)'(DEPTH));
			valid_reg <= (count_next != '0);
		end
	end

endmodule : mpic_fifo

`default_nettype wire

// >>> rtl/mpic_top.sv
// Summary of operation
// - Every pixel input is captured on the rising clock edge and that one clock paces all pixel and coefficient flow.
// - The registered A-channel word, masked, addresses the colour look-up table entries.
// - Software can bypass the A-channel look-up tables so the masked word passes on untranslated.
// - In colour-index mode the low eight A-channel bits address all three table sections together.
// - The registered B-channel word goes to the mixer, through interpolation when that is selected.
// - The 9-bit coefficient is registered on each clock that PIX_READY is high and passed on for proportional mixing, bit zero the LSB.
// - The top coefficient bit acts as a key choosing A-channel or B-channel data pixel by pixel.
// - The select pins steer the crosspoint only while the control field holds 111 and are ignored otherwise.
// - The crosspoint routes A, B or the fill colour to each of the two mixer operands.
// - The select pins are sampled on the rising clock edge together with the pixel data.
//
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "mpic_consts.svh"

module mpic_top
	import mpic_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Wishbone slave
	input wire logic [7:0] WB_ADR_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic WB_WE_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// Pixel sources
	input wire logic [23:0] FIRST_PIXEL_IN,
	input wire logic [23:0] SECOND_PIXEL_IN,
	input wire logic [8:0] COEF_IN,
	input wire logic [2:0] OPERAND_SELECT_PINS,
	input wire logic PIX_VALID,
	output logic PIX_READY,
	// Mixer core
	output logic [23:0] MIXER_OPERAND_ONE,
	output logic [23:0] MIXER_OPERAND_TWO,
	output logic [8:0] MIX_COEF,
	output logic MIX_VALID,
	input wire logic MIX_READY
);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] wdat, input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = wdat[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge_sel

	function automatic mpic_src_e [1:0] decode_pair(input logic [2:0] code);
		mpic_src_e [1:0] p;
		unique case (code)
			3'h0: begin
				p[1] = MPIC_SRC_A;
				p[0] = MPIC_SRC_B;
			end
			3'h1: begin
				p[1] = MPIC_SRC_A;
				p[0] = MPIC_SRC_F;
			end
			3'h2: begin
				p[1] = MPIC_SRC_B;
				p[0] = MPIC_SRC_A;
			end
			3'h3: begin
				p[1] = MPIC_SRC_B;
				p[0] = MPIC_SRC_F;
			end
			3'h4: begin
				p[1] = MPIC_SRC_F;
				p[0] = MPIC_SRC_A;
			end
			3'h5: begin
				p[1] = MPIC_SRC_F;
				p[0] = MPIC_SRC_B;
			end
			default: begin
				p[1] = MPIC_SRC_A;
				p[0] = MPIC_SRC_B;
			end
		endcase
		return p;
	endfunction : decode_pair

	function automatic mpic_pix_t pick(input mpic_src_e s, input mpic_pix_t a, input mpic_pix_t b, input mpic_pix_t f);
		mpic_pix_t r;
		unique case (s)
			MPIC_SRC_A: r = a;
			MPIC_SRC_B: r = b;
			default: r = f;
		endcase
		return r;
	endfunction : pick

	// ****************************************************************
	// Register file
	// ****************************************************************
	logic [`MPIC_CTRL_WIDTH-1:0] ctrl_reg;
	mpic_pix_t fill_reg;
	mpic_pix_t mask_reg;
	logic [7:0] lut_addr_reg;
	mpic_pix_t lut_mem [`MPIC_LUT_DEPTH];
	logic [31:0] rdata_reg;
	logic ack_reg;
	logic wb_req;
	logic wb_wr;
	logic [31:0] rd_mux;
	logic [2:0] active_sel;
	logic fifo_ready;
	logic fifo_valid;

	assign wb_req = WB_CYC_I && WB_STB_I && !ack_reg;
	assign wb_wr = wb_req && WB_WE_I;
	assign WB_ACK_O = ack_reg;
	assign WB_DAT_O = rdata_reg;

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= wb_req;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ctrl_reg <= `MPIC_CTRL_RESET;
			fill_reg <= `MPIC_FILL_RESET;
			mask_reg <= `MPIC_MASK_RESET;
		end else if (wb_wr) begin
			unique case (WB_ADR_I)
				`MPIC_OFS_CTRL: begin
					ctrl_reg <= (`MPIC_CTRL_WIDTH)'(merge_sel(32'(ctrl_reg), WB_DAT_I, WB_SEL_I));
				end
				`MPIC_OFS_FILL: begin
					fill_reg <= mpic_pix_t'(merge_sel(32'(fill_reg), WB_DAT_I, WB_SEL_I));
				end
				`MPIC_OFS_MASK: begin
					mask_reg <= mpic_pix_t'(merge_sel(32'(mask_reg), WB_DAT_I, WB_SEL_I));
				end
				default: ;
			endcase
		end
	end

	// Table pointer steps after each data access
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			lut_addr_reg <= 8'h00;
		end else if (wb_wr && WB_ADR_I == `MPIC_OFS_LUT_ADDR && WB_SEL_I[0]) begin
			lut_addr_reg <= WB_DAT_I[7:0];
		end else if (wb_req && WB_ADR_I == `MPIC_OFS_LUT_DATA) begin
			lut_addr_reg <= lut_addr_reg + 8'h01;
		end
	end

	always_ff @(posedge CLK) begin
		if (wb_wr && WB_ADR_I == `MPIC_OFS_LUT_DATA) begin
			lut_mem[lut_addr_reg] <= mpic_pix_t'(merge_sel(32'(lut_mem[lut_addr_reg]), WB_DAT_I, WB_SEL_I));
		end
	end

	always_comb begin
		unique case (WB_ADR_I)
			`MPIC_OFS_CTRL: rd_mux = 32'(ctrl_reg);
			`MPIC_OFS_FILL: rd_mux = 32'(fill_reg);
			`MPIC_OFS_MASK: rd_mux = 32'(mask_reg);
			`MPIC_OFS_LUT_ADDR: rd_mux = 32'(lut_addr_reg);
			`MPIC_OFS_LUT_DATA: rd_mux = 32'(lut_mem[lut_addr_reg]);
			`MPIC_OFS_STATUS: rd_mux = {27'h0000000, fifo_valid, fifo_ready, active_sel};
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			rdata_reg <= 32'h00000000;
		end else if (wb_req && !WB_WE_I) begin
			rdata_reg <= rd_mux;
		end
	end

	// ****************************************************************
	// Input capture stage
	// ****************************************************************
	logic pipe_en;
	mpic_pix_t a_in_reg;
	mpic_pix_t b_in_reg;
	logic [8:0] coef_in_reg;
	logic [2:0] pins_reg;
	logic in_valid_reg;

	assign pipe_en = fifo_ready;
	assign PIX_READY = fifo_ready;

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			a_in_reg <= '0;
			b_in_reg <= '0;
			coef_in_reg <= '0;
			pins_reg <= '0;
			in_valid_reg <= 1'b0;
		end else if (pipe_en) begin
			a_in_reg <= FIRST_PIXEL_IN;
			b_in_reg <= SECOND_PIXEL_IN;
			coef_in_reg <= COEF_IN;
			pins_reg <= OPERAND_SELECT_PINS;
			in_valid_reg <= PIX_VALID;
		end
	end

	// ****************************************************************
	// A-channel lookup and B-channel interpolation
	// ****************************************************************
	mpic_pix_t a_masked;
	mpic_pix_t a_path;
	mpic_pix_t b_path;
	mpic_pix_t b_prev_reg;
	logic [8:0] cb_sum;
	logic [8:0] cr_sum;

	assign a_masked = a_in_reg & mask_reg;

	always_comb begin
		if (ctrl_reg[`MPIC_CTRL_BYPASS]) begin
			a_path = a_masked;
		end else if (ctrl_reg[`MPIC_CTRL_INDEX]) begin
			a_path = lut_mem[a_masked[7:0]];
		end else begin
			a_path = {lut_mem[a_masked[23:16]][23:16], lut_mem[a_masked[15:8]][15:8],
				lut_mem[a_masked[7:0]][7:0]};
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			b_prev_reg <= '0;
		end else if (pipe_en && in_valid_reg) begin
			b_prev_reg <= b_in_reg;
		end
	end

	// Chroma averaged with the previous pixel fills the missing 4:2:2 samples
	assign cb_sum = {1'b0, b_in_reg[7:0]} + {1'b0, b_prev_reg[7:0]};
	assign cr_sum = {1'b0, b_in_reg[23:16]} + {1'b0, b_prev_reg[23:16]};
	assign b_path = ctrl_reg[`MPIC_CTRL_INTERP] ? {cr_sum[8:1], b_in_reg[15:8], cb_sum[8:1]} : b_in_reg;

	// ****************************************************************
	// Crosspoint
	// ****************************************************************
	mpic_src_e [1:0] pair;
	mpic_word_s word;
	logic key_a;

	assign active_sel = (ctrl_reg[`MPIC_CTRL_XPT_MSB:`MPIC_CTRL_XPT_LSB] == `MPIC_XPT_PINS) ?
		pins_reg : ctrl_reg[`MPIC_CTRL_XPT_MSB:`MPIC_CTRL_XPT_LSB];
	assign pair = decode_pair(active_sel);
	assign key_a = coef_in_reg[8];

	always_comb begin
		word.coef = coef_in_reg;
		if (ctrl_reg[`MPIC_CTRL_KEY]) begin
			word.one = key_a ? a_path : b_path;
			word.two = key_a ? a_path : b_path;
		end else begin
			word.one = pick(pair[1], a_path, b_path, fill_reg);
			word.two = pick(pair[0], a_path, b_path, fill_reg);
		end
	end

	// ****************************************************************
	// Output buffer
	// ****************************************************************
	mpic_fifo_if #(.WIDTH($bits(mpic_word_s))) fifo_bus ();
	mpic_word_s out_word;

	assign fifo_bus.in_valid = in_valid_reg;
	assign fifo_bus.in_data = word;
	assign fifo_bus.out_ready = MIX_READY;
	assign fifo_ready = fifo_bus.in_ready;
	assign fifo_valid = fifo_bus.out_valid;
	assign out_word = fifo_bus.out_data;

	mpic_fifo #(
		.WIDTH($bits(mpic_word_s)),
		.DEPTH(`MPIC_FIFO_DEPTH)
	) u_fifo (
		.clk(CLK),
		.rst_n(RST_N),
		.port(fifo_bus.buffer)
	);

	assign MIXER_OPERAND_ONE = out_word.one;
	assign MIXER_OPERAND_TWO = out_word.two;
	assign MIX_COEF = out_word.coef;
	assign MIX_VALID = fifo_valid;

endmodule : mpic_top

`default_nettype wire

// >>> verif/mpic_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checks
// ****
module mpic_top_sva (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// Wishbone
	input wire logic WB_WE_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	// Pixels
	input wire logic PIX_VALID,
	input wire logic PIX_READY,
	input wire logic [23:0] MIXER_OPERAND_ONE,
	input wire logic [23:0] MIXER_OPERAND_TWO,
	input wire logic [8:0] MIX_COEF,
	input wire logic MIX_VALID,
	input wire logic MIX_READY
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	wire logic req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
	ack_time_a: assert property (req |=> WB_ACK_O) else $error("ack late");
	ack_cause_a: assert property ($rose(WB_ACK_O) |-> $past(req)) else $error("ack unasked");
	rst_quiet_a: assert property (disable iff (1'b0) !RST_N |=> !WB_ACK_O && !PIX_READY && !MIX_VALID)
		else $error("busy in reset");
	hold_out_a: assert property (MIX_VALID && !MIX_READY |=> MIX_VALID && $stable(MIXER_OPERAND_ONE)
		&& $stable(MIXER_OPERAND_TWO) && $stable(MIX_COEF)) else $error("word lost");
	ready_rise_a: assert property ($rose(RST_N) |=> PIX_READY) else $error("not ready");
	pix_latency_a: assert property (PIX_VALID && PIX_READY && !MIX_VALID |-> ##[1:3] MIX_VALID)
		else $error("word late");
	dat_hold_a: assert property (!(req && !WB_WE_I) |=> $stable(WB_DAT_O)) else $error("data moved");
endmodule : mpic_top_sva

bind mpic_top mpic_top_sva mpic_top_sva_inst (.CLK(CLK), .RST_N(RST_N), .WB_WE_I(WB_WE_I),
	.WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
	.PIX_VALID(PIX_VALID), .PIX_READY(PIX_READY), .MIXER_OPERAND_ONE(MIXER_OPERAND_ONE),
	.MIXER_OPERAND_TWO(MIXER_OPERAND_TWO), .MIX_COEF(MIX_COEF), .MIX_VALID(MIX_VALID),
	.MIX_READY(MIX_READY));
`default_nettype wire

// >>> verif/mpic_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Upstream pixel source
// ****
module mpic_src_model (
	// Clock
	input wire logic clk,
	// Bench control
	input wire logic en,
	input wire logic [2:0] sel,
	output logic [7:0] n,
	// Pixel bus
	output logic [23:0] a,
	output logic [23:0] b,
	output logic [8:0] coef,
	output logic [2:0] pins,
	output logic valid,
	input wire logic ready
);
	logic run = 1'b0;
	initial n = 8'h00;
	// Word is held until taken
	always @(posedge clk) begin
		if (valid && ready)
			n <= n + 8'h01;
		if (!valid || ready)
			run <= en;
	end
	// Idle lines show the inverse of the word
	assign valid = run;
	assign a = run ? {3{n}} : ~{3{n}};
	assign b = run ? ~{3{n}} : {3{n}};
	assign coef = run ? {n[0], n} : ~{n[0], n};
	assign pins = run ? sel : ~sel;
endmodule : mpic_src_model
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mpic_consts.svh"
module tb_top
	import mpic_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n, cyc, stb, we, mr, en, hold, key, idx, interp, pv, rdy, mv, ack;
	logic [7:0] adr, n, last, pops, nx;
	logic [31:0] dw, dr, q;
	logic [23:0] a, b, mask, fill, o1, o2;
	logic [8:0] coef, mc;
	logic [2:0] sel, pins, code;
	logic [1:0] s1, s2;
	logic [3:0] pr [6] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'h9};
	int failures = 0;
	int comparisons = 0;
	always #4 clk = ~clk;
	mpic_top mpic_top_inst (.CLK(clk), .RST_N(rst_n), .WB_ADR_I(adr), .WB_DAT_I(dw), .WB_SEL_I(4'hF),
		.WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_DAT_O(dr), .WB_ACK_O(ack),
		.FIRST_PIXEL_IN(a), .SECOND_PIXEL_IN(b), .COEF_IN(coef), .OPERAND_SELECT_PINS(pins),
		.PIX_VALID(pv), .PIX_READY(rdy), .MIXER_OPERAND_ONE(o1), .MIXER_OPERAND_TWO(o2),
		.MIX_COEF(mc), .MIX_VALID(mv), .MIX_READY(mr));
	mpic_src_model mpic_src_model_inst (.clk(clk), .en(en), .sel(sel), .n(n), .a(a), .b(b),
		.coef(coef), .pins(pins), .valid(pv), .ready(rdy));
	// ****
	// Helpers
	// ****
	function automatic mpic_pix_t lut(input logic [7:0] x);
		return {x ^ 8'h5A, 8'hC3, x};
	endfunction : lut
	function automatic logic [7:0] avg(input logic [7:0] x, input logic [7:0] y);
		logic [8:0] t;
		t = {1'b0, x} + {1'b0, y};
		return t[8:1];
	endfunction : avg
	function automatic mpic_pix_t src(input logic [1:0] s, input logic [7:0] c);
		if (s == 2'h1)
			return interp ? {avg(~c, ~(c - 8'h01)), ~c, avg(~c, ~(c - 8'h01))} : ~{3{c}};
		if (s == 2'h2)
			return fill;
		return idx ? lut(c) : {3{c}} & mask;
	endfunction : src
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			failures++;
			$display("mismatch %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic end_of_test;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= ad;
		dw <= d;
		do
			@(posedge clk);
		while (ack !== 1'b1);
		q = dr;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic run(input logic [6:0] c, input logic [2:0] s);
		key = c[6];
		idx = !c[0];
		interp = c[5];
		code = s;
		sel <= (c[4:2] == 3'h7) ? s : 3'h5 - s;
		wb(1'b1, `MPIC_OFS_CTRL, {25'h0, c});
		en <= 1'b1;
		repeat (12) @(posedge clk);
		en <= 1'b0;
		repeat (60) @(posedge clk);
	endtask : run
	// ****
	// Mixer side
	// ****
	always @(posedge clk)
		mr <= hold ? 1'b0 : ~mr;
	always @(posedge clk) begin
		if (rst_n && mv === 1'b1 && mr) begin
			nx = last + 8'h01;
			s1 = key ? {1'b0, ~nx[0]} : pr[code][3:2];
			s2 = key ? {1'b0, ~nx[0]} : pr[code][1:0];
			chk({23'h0, mc}, {23'h0, nx[0], nx});
			chk({8'h0, o1}, {8'h0, src(s1, nx)});
			chk({8'h0, o2}, {8'h0, src(s2, nx)});
			last = nx;
			pops++;
		end
	end
	// ****
	// Sequence
	// ****
	initial begin
		rst_n = 1'b0;
		{cyc, stb, we, mr, en, hold, key, idx, interp} = 9'h000;
		{adr, dw, sel, code, fill, pops} = '0;
		last = 8'hFF;
		mask = 24'hFFFFFF;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		wb(1'b0, `MPIC_OFS_CTRL, 32'h0);
		chk(q, 32'h01);
		wb(1'b0, `MPIC_OFS_MASK, 32'h0);
		chk(q, 32'h00FFFFFF);
		wb(1'b1, 8'h40, 32'hFFFFFFFF);
		wb(1'b0, 8'h40, 32'h0);
		chk(q, 32'h0);
		fill = 24'h123456;
		wb(1'b1, `MPIC_OFS_FILL, {8'h0, fill});
		for (int i = 0; i < 12; i++)
			run({2'h0, (i < 6) ? 3'(i) : 3'h7, 2'h1}, 3'(i % 6));
		mask = 24'h0F0F0F;
		wb(1'b1, `MPIC_OFS_MASK, {8'h0, mask});
		run(7'h41, 3'h0);
		mask = 24'hFFFFFF;
		wb(1'b1, `MPIC_OFS_MASK, {8'h0, mask});
		wb(1'b1, `MPIC_OFS_LUT_ADDR, 32'h0);
		for (int i = 0; i < 256; i++)
			wb(1'b1, `MPIC_OFS_LUT_DATA, {8'h0, lut(8'(i))});
		run(7'h02, 3'h0);
		run(7'h00, 3'h0);
		run(7'h21, 3'h0);
		hold <= 1'b1;
		en <= 1'b1;
		repeat (40) @(posedge clk);
		chk({31'h0, rdy}, 32'h0);
		chk({31'h0, mv}, 32'h1);
		en <= 1'b0;
		hold <= 1'b0;
		repeat (80) @(posedge clk);
		chk({24'h0, pops}, {24'h0, n});
		end_of_test;
	end
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		end_of_test;
	end
endmodule : tb_top
`default_nettype wire
